// >>> hdl/hcs_hyp_control_syndrome.v
`timescale 1ns/1ps
`include "hcs_consts.vh"
module hcs_hyp_control_syndrome #(
  parameter HAS_ITD = 1,
  parameter HAS_BEN = 1
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // coprocessor move
  input  wire        cpValid,
  input  wire        cpWrite,
  input  wire [2:0]  cpOpc1,
  input  wire [2:0]  cpOpc2,
  input  wire [3:0]  cpCrn,
  input  wire [3:0]  cpCrm,
  input  wire [3:0]  cpCoproc,
  input  wire [31:0] cpWdata,
  input  wire        cpToSyndrome,
  input  wire [1:0]  curLevel,
  input  wire        guestTrapGeneral,
  input  wire        hypTrapGroupOne,
  output reg  [31:0] cpRdata,
  output reg         cpDone,
  output reg         cpUndef,
  output reg         cpTrapHyp,
  // instruction check
  input  wire        insnValid,
  input  wire        insnInItBlock,
  input  wire [15:0] insnHw1,
  input  wire        insnIsBarrier,
  output reg         insnUndef,
  // data access
  input  wire        accValid,
  input  wire [2:0]  accAddrLow,
  input  wire [1:0]  accSizeLog2,
  input  wire        accExclusive,
  input  wire        accAcqRel,
  output reg         alignFault,
  // exception capture
  input  wire        excValid,
  input  wire [3:0]  excKind,
  input  wire        excFromLower,
  input  wire        excAltCoproc,
  input  wire        excVfpAbsent,
  input  wire        excCondFail,
  input  wire        excIl,
  input  wire [24:0] excIss,
  output reg         excTaken,
  // control outputs
  output reg         dataCacheable,
  output reg         mpuOn,
  output reg  [31:0] syndrome
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg        itdQ, benQ, cQ, aQ, mQ;
  reg [31:0] synQ;
  wire [31:0] ctlView = {24'h0, (HAS_ITD ? itdQ : 1'b0), 1'b0, (HAS_BEN ? benQ : 1'b1),
                         2'h3, cQ, aQ, mQ};
  wire encHit = (cpOpc1 == `HCS_ENC_OPC1) & (cpOpc2 == `HCS_ENC_OPC2) & (cpCrn == `HCS_ENC_CRN) &
                (cpCoproc == `HCS_ENC_CP) & (cpCrm == `HCS_ENC_CRM);
  wire isHyp = (curLevel == `HCS_LVL_HYP);
  wire supTrap = (curLevel == `HCS_LVL_SUP) & hypTrapGroupOne & ~guestTrapGeneral;
  wire ctlHit = cpValid & encHit & ~cpToSyndrome;
  wire synHit = cpValid & cpToSyndrome;
  wire grant = isHyp & (ctlHit | synHit);
  wire wrCtl = ctlHit & isHyp & cpWrite;
  wire wrSyn = synHit & isHyp & cpWrite;
  // ---------------------------------------------------------------
  // instruction disable and alignment
  // ---------------------------------------------------------------
  // pattern test ignores condition pass or fail on purpose
  wire itPcHit = (insnHw1[15:10] == 6'h11) & insnHw1[7] & (insnHw1[2:0] == 3'h7);
  wire undefNext = insnValid & isHyp &
                   (((HAS_ITD != 0) & itdQ & insnInItBlock & itPcHit) |
                    ((HAS_BEN != 0) & ~benQ & insnIsBarrier));
  wire alignNext;
  hcs_align_check uAlign (
    .accValid    (accValid & isHyp),
    .accAddrLow  (accAddrLow),
    .accSizeLog2 (accSizeLog2),
    .accExclusive(accExclusive),
    .accAcqRel   (accAcqRel),
    .alignEnable (aQ),
    .alignFault  (alignNext)
  );
  // ---------------------------------------------------------------
  // exception class encoding
  // ---------------------------------------------------------------
  reg [5:0] ecD;
  reg       takeD;
  always @* begin
    takeD = excValid;
    case (excKind)
      `HCS_EV_UNKNOWN: ecD = `HCS_EC_UNKNOWN;
      `HCS_EV_WAIT: begin
        ecD = `HCS_EC_WAIT;
        takeD = excValid & ~excCondFail;
      end
      `HCS_EV_MOV: ecD = excAltCoproc ? `HCS_EC_MOV1ALT : `HCS_EC_MOV1;
      `HCS_EV_MOV2: ecD = excAltCoproc ? `HCS_EC_RD2ALT : `HCS_EC_MOV2;
      `HCS_EV_LDST: ecD = `HCS_EC_LDST;
      `HCS_EV_VFP: ecD = excVfpAbsent ? `HCS_EC_UNKNOWN : `HCS_EC_VFP;
      `HCS_EV_IDREAD: ecD = `HCS_EC_IDREAD;
      `HCS_EV_ILLRET: ecD = `HCS_EC_ILLRET;
      `HCS_EV_SVC: ecD = `HCS_EC_SVC;
      `HCS_EV_HVC: ecD = `HCS_EC_HVC;
      `HCS_EV_PABT: ecD = excFromLower ? `HCS_EC_PABT_LO : `HCS_EC_PABT_SM;
      `HCS_EV_PCALIGN: ecD = `HCS_EC_PCALIGN;
      `HCS_EV_DABT: ecD = excFromLower ? `HCS_EC_DABT_LO : `HCS_EC_DABT_SM;
      // reserved kinds fall back to unknown so exception capture never writes a reserved class; a software write stores cpWdata unchecked
      default: ecD = `HCS_EC_UNKNOWN;
    endcase
  end
  // unknown class carries no instruction detail, keeping the value legitimate
  wire [31:0] synNew = (ecD == `HCS_EC_UNKNOWN) ? {ecD, 1'b1, 25'h0} : {ecD, excIl, excIss};
  // ---------------------------------------------------------------
  // sequential
  // ---------------------------------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      itdQ <= 1'b0;
      benQ <= 1'b1;
      cQ <= 1'b0;
      aQ <= 1'b0;
      mQ <= 1'b0;
      synQ <= 32'h00000000;
      cpRdata <= 32'h00000000;
      cpDone <= 1'b0;
      cpUndef <= 1'b0;
      cpTrapHyp <= 1'b0;
      insnUndef <= 1'b0;
      alignFault <= 1'b0;
      excTaken <= 1'b0;
      dataCacheable <= 1'b0;
      mpuOn <= 1'b0;
      syndrome <= 32'h00000000;
    end else begin
      if (wrCtl) begin
        itdQ <= cpWdata[`HCS_BIT_ITD];
        benQ <= cpWdata[`HCS_BIT_BEN];
        cQ <= cpWdata[`HCS_BIT_C];
        aQ <= cpWdata[`HCS_BIT_A];
        mQ <= cpWdata[`HCS_BIT_M];
      end
      // hardware capture wins over a software write in the same cycle
      if (takeD)
        synQ <= synNew;
      else if (wrSyn)
        synQ <= cpWdata;
      cpDone <= cpValid;
      cpTrapHyp <= cpValid & encHit & ~cpToSyndrome & supTrap;
      cpUndef <= (ctlHit | synHit) & ~isHyp & ~(ctlHit & supTrap);
      cpRdata <= (grant & ~cpWrite) ? (synHit ? synQ : ctlView) : 32'h00000000;
      insnUndef <= undefNext;
      alignFault <= alignNext;
      excTaken <= takeD;
      dataCacheable <= cQ;
      mpuOn <= mQ;
      syndrome <= takeD ? synNew : (wrSyn ? cpWdata : synQ);
    end
  end
endmodule

// >>> hdl/hcs_consts.vh
// Summary of operation
// - it_block_disable set makes IT-block PC-targeting halfword 010001xx1xxxx111 undefined.
// - such disabled instructions are undefined whatever their IT condition result.
// - IT may pair as 16+16 or head a 32-bit unit; fault unit follows.
// - it_block_disable optional; absent reads zero, ignores writes; resets unknown otherwise.
// - barrier_instr_enable bit 5: 0 undefines legacy barriers; absent reads one.
// - data_cache_enable bit 2 gives hypervisor data cacheability; resets to zero.
// - align_check_enable 0 skips alignment check except exclusive and acquire/release.
// - align_check_enable 1 checks every access; failure is an alignment data abort.
// - exclusive and acquire/release accesses always check alignment.
// - mpu_enable bit 0 turns the hypervisor protection unit on; resets zero.
// - control register decoded at opc1 100, opc2 000, CRn 0001, cp 1111, CRm 0000.
// - control register read-write at hypervisor level only; user and supervisor denied.
// - hyp_trap_group_one set traps supervisor accesses to hypervisor mode; the code makes them undefined instead while guestTrapGeneral is set.
// - syndrome register is 32 bits, captures exceptions taken to hypervisor mode.
// - syndrome for unpredictable-as-undefined must look like a legitimate same-level one.
// - class 000000 unknown, 000001 wait trap; failed-condition waits never trap.
// - classes 000011, 000100, 000101 for coprocessor move traps.
// - classes 000110 load/store, 000111 vector trap, absent vector 000000, 001000 ID read.
// - classes 001100 two-register read, 001110 illegal return, 010001 routed call.
// - classes 010010 hypervisor call, 100000 and 100001 prefetch aborts.
// - classes 100010 PC alignment, 100100 lower-level data abort.
// - class 100101 same-level data abort; other values reserved.
`ifndef HCS_CONSTS_VH
`define HCS_CONSTS_VH
`define HCS_BIT_ITD     7
`define HCS_BIT_BEN     5
`define HCS_BIT_C       2
`define HCS_BIT_A       1
`define HCS_BIT_M       0
`define HCS_RES1_MASK   32'h00000018
`define HCS_ENC_OPC1    3'h4
`define HCS_ENC_OPC2    3'h0
`define HCS_ENC_CRN     4'h1
`define HCS_ENC_CP      4'hF
`define HCS_ENC_CRM     4'h0
`define HCS_CP_ALT      4'hE
`define HCS_LVL_USR     2'h0
`define HCS_LVL_SUP     2'h1
`define HCS_LVL_HYP     2'h2
`define HCS_EC_UNKNOWN  6'h00
`define HCS_EC_WAIT     6'h01
`define HCS_EC_MOV1     6'h03
`define HCS_EC_MOV2     6'h04
`define HCS_EC_MOV1ALT  6'h05
`define HCS_EC_LDST     6'h06
`define HCS_EC_VFP      6'h07
`define HCS_EC_IDREAD   6'h08
`define HCS_EC_RD2ALT   6'h0C
`define HCS_EC_ILLRET   6'h0E
`define HCS_EC_SVC      6'h11
`define HCS_EC_HVC      6'h12
`define HCS_EC_PABT_LO  6'h20
`define HCS_EC_PABT_SM  6'h21
`define HCS_EC_PCALIGN  6'h22
`define HCS_EC_DABT_LO  6'h24
`define HCS_EC_DABT_SM  6'h25
`define HCS_EV_UNKNOWN  4'h0
`define HCS_EV_WAIT     4'h1
`define HCS_EV_MOV      4'h2
`define HCS_EV_MOV2     4'h3
`define HCS_EV_LDST     4'h4
`define HCS_EV_VFP      4'h5
`define HCS_EV_IDREAD   4'h6
`define HCS_EV_ILLRET   4'h7
`define HCS_EV_SVC      4'h8
`define HCS_EV_HVC      4'h9
`define HCS_EV_PABT     4'hA
`define HCS_EV_PCALIGN  4'hB
`define HCS_EV_DABT     4'hC
`endif

// >>> hdl/hcs_align_check.v
`timescale 1ns/1ps
`include "hcs_consts.vh"
module hcs_align_check (
  // access
  input  wire       accValid,
  input  wire [2:0] accAddrLow,
  input  wire [1:0] accSizeLog2,
  input  wire       accExclusive,
  input  wire       accAcqRel,
  // control
  input  wire       alignEnable,
  // result
  output wire       alignFault
);
  reg [2:0] mask;
  always @* begin
    case (accSizeLog2)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
  end
  wire mustCheck = alignEnable | accExclusive | accAcqRel;
  assign alignFault = accValid & mustCheck & (|(accAddrLow & mask));
endmodule

// >>> verification/hcs_monitor.sv
`timescale 1ns/1ps
`include "hcs_consts.vh"
module hcs_monitor (
  // clock and reset
  input wire        sys_clk,
  input wire        rst,
  // requests
  input wire        cpValid,
  input wire [1:0]  curLevel,
  input wire        hypTrapGroupOne,
  input wire        accValid,
  input wire [2:0]  accAddrLow,
  input wire [1:0]  accSizeLog2,
  input wire        accExclusive,
  input wire        excValid,
  input wire [3:0]  excKind,
  input wire        excCondFail,
  // answers
  input wire        cpDone,
  input wire [31:0] cpRdata,
  input wire        cpTrapHyp,
  input wire        alignFault,
  input wire        excTaken,
  input wire        dataCacheable,
  input wire        mpuOn,
  input wire [31:0] syndrome
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire waitFail = excValid && excKind == `HCS_EV_WAIT && excCondFail;
  wire isHyp    = curLevel == `HCS_LVL_HYP;
  AST_CP_DONE: assert property (cpValid |=> cpDone)
    else $error("move not answered");
  AST_DENY_NO_DATA: assert property (cpValid && !isHyp |=> cpRdata == 32'h00000000)
    else $error("denied access returned data");
  AST_TRAP_CAUSE: assert property (cpTrapHyp |-> $past(hypTrapGroupOne && curLevel == `HCS_LVL_SUP))
    else $error("trap without supervisor trap setting");
  AST_ALIGN_EXCL: assert property (accValid && isHyp && accExclusive && accAddrLow[0] && accSizeLog2 != 2'h0 |=> alignFault)
    else $error("exclusive misalignment not faulted");
  AST_ALIGNED_OK: assert property (accValid && accAddrLow == 3'h0 |=> !alignFault)
    else $error("aligned access faulted");
  // control outputs may only move after a register write
  AST_CTRL_HOLD: assert property (!cpValid && !$past(cpValid) |=> $stable({dataCacheable, mpuOn}))
    else $error("control output moved without write");
  AST_EXC_TAKEN: assert property (excValid && !waitFail |=> excTaken)
    else $error("exception not captured");
  // a software write in the same cycle may still move the syndrome
  AST_WAIT_FAIL: assert property (waitFail |=> !excTaken && ($stable(syndrome) || $past(cpValid)))
    else $error("failed wait trapped");
  AST_EC_HVC: assert property (excValid && excKind == `HCS_EV_HVC |=> syndrome[31:26] == `HCS_EC_HVC)
    else $error("wrong class for call");
  cover property (cpValid && curLevel == `HCS_LVL_SUP ##1 cpTrapHyp);
  cover property (alignFault);
  cover property (excTaken && syndrome[31:26] == `HCS_EC_HVC);
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
`include "hcs_consts.vh"
module tb;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         cpValid, cpWrite, cpToSyndrome, guestTrapGeneral, hypTrapGroupOne;
  reg         insnValid, insnInItBlock, insnIsBarrier, accValid, accExclusive, accAcqRel;
  reg         excValid, excFromLower, excAltCoproc, excVfpAbsent, excCondFail;
  reg  [1:0]  curLevel, accSizeLog2;
  reg  [2:0]  accAddrLow;
  reg  [3:0]  cpCrm, excKind;
  reg  [15:0] insnHw1;
  reg  [24:0] excIss;
  reg  [31:0] cpWdata;
  wire [31:0] cpRdata, syndrome;
  wire        cpDone, cpUndef, cpTrapHyp, insnUndef, alignFault, excTaken, dataCacheable, mpuOn;
  integer     err_total = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  // per entry: kind, {lower, alt, absent, 0}, expected class
  localparam [271:0] EXC = 272'h1001_2003_2405_3004_340C_4006_5007_5200_6008_700E_8011_A820_A021_B022_C824_C025_9012;
  hcs_hyp_control_syndrome dut (.sys_clk, .rst, .cpValid, .cpWrite, .cpOpc1(`HCS_ENC_OPC1), .cpOpc2(`HCS_ENC_OPC2),
    .cpCrn(`HCS_ENC_CRN), .cpCrm, .cpCoproc(`HCS_ENC_CP), .cpWdata, .cpToSyndrome, .curLevel, .guestTrapGeneral,
    .hypTrapGroupOne, .cpRdata, .cpDone, .cpUndef, .cpTrapHyp, .insnValid, .insnInItBlock, .insnHw1, .insnIsBarrier,
    .insnUndef, .accValid, .accAddrLow, .accSizeLog2, .accExclusive, .accAcqRel, .alignFault, .excValid, .excKind,
    .excFromLower, .excAltCoproc, .excVfpAbsent, .excCondFail, .excIl(1'b1), .excIss, .excTaken, .dataCacheable,
    .mpuOn, .syndrome);
  initial forever #2.5 sys_clk = ~sys_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // m[0] spoils the encoding, m[1] selects the syndrome register; tt is {guest, group one}
  task cp(input w, input [1:0] lv, input [1:0] tt, input [1:0] m, input [31:0] d);
    begin
      @(posedge sys_clk);
      cpValid <= 1'b1;
      cpWrite <= w;
      curLevel <= lv;
      {guestTrapGeneral, hypTrapGroupOne} <= tt;
      cpCrm <= {3'h0, m[0]};
      cpToSyndrome <= m[1];
      cpWdata <= d;
      @(posedge sys_clk);
      cpValid <= 1'b0;
      #1;
      chk(cpDone, 1'b1);
    end
  endtask
  task ins(input [15:0] hw, input it, input bar, input exp);
    begin
      @(posedge sys_clk);
      {insnValid, insnHw1, insnInItBlock, insnIsBarrier, curLevel} <= {1'b1, hw, it, bar, 2'h2};
      @(posedge sys_clk);
      insnValid <= 1'b0;
      #1;
      chk(insnUndef, exp);
    end
  endtask
  // k is {size, exclusive, acquire-release}
  task ac(input [2:0] ad, input [3:0] k, input exp);
    begin
      @(posedge sys_clk);
      {accValid, accAddrLow, accSizeLog2, accExclusive, accAcqRel, curLevel} <= {1'b1, ad, k, 2'h2};
      @(posedge sys_clk);
      accValid <= 1'b0;
      #1;
      chk(alignFault, exp);
    end
  endtask
  task ex(input [15:0] e, input cf);
    reg [31:0] prev;
    begin
      prev = syndrome;
      @(posedge sys_clk);
      {excValid, excKind, excFromLower, excAltCoproc, excVfpAbsent} <= {1'b1, e[15:9]};
      excCondFail <= cf;
      excIss <= {9'h1FF, e};
      @(posedge sys_clk);
      excValid <= 1'b0;
      #1;
      chk(excTaken, !cf);
      if (cf)
        chk(syndrome, prev);
      else
        chk(syndrome[31:26], e[5:0]);
    end
  endtask
  task s_ctrl;
    begin
      cp(1'b0, 2'h2, 2'h0, 2'h0, 32'h0);
      chk(cpRdata, 32'h38);
      chk({dataCacheable, mpuOn}, 2'h0);
      cp(1'b1, 2'h2, 2'h0, 2'h0, 32'hFFFFFFFF);
      cp(1'b0, 2'h2, 2'h0, 2'h0, 32'h0);
      chk(cpRdata, 32'hBF);
      chk({dataCacheable, mpuOn}, 2'h3);
      cp(1'b0, 2'h2, 2'h0, 2'h1, 32'h0);
      chk(cpRdata, 32'h0);
    end
  endtask
  task s_insn;
    begin
      ins(16'h4487, 1'b1, 1'b0, 1'b1);
      ins(16'h4487, 1'b0, 1'b0, 1'b0);
      ins(16'h4407, 1'b1, 1'b0, 1'b0);
      ins(16'hF0F0, 1'b0, 1'b1, 1'b0);
      cp(1'b1, 2'h2, 2'h0, 2'h0, 32'h02);
      ins(16'hF0F0, 1'b0, 1'b1, 1'b1);
    end
  endtask
  task s_align;
    begin
      cp(1'b0, 2'h2, 2'h0, 2'h0, 32'h0);
      chk(cpRdata, 32'h1A);
      ac(3'h2, 4'h8, 1'b1);
      ac(3'h4, 4'h8, 1'b0);
      ac(3'h7, 4'h0, 1'b0);
      cp(1'b1, 2'h2, 2'h0, 2'h0, 32'h0);
      ac(3'h2, 4'h8, 1'b0);
      ac(3'h2, 4'hA, 1'b1);
      ac(3'h1, 4'h5, 1'b1);
      ac(3'h1, 4'h6, 1'b1);
    end
  endtask
  task s_access;
    begin
      cp(1'b0, 2'h0, 2'h0, 2'h0, 32'h0);
      chk(cpUndef, 1'b1);
      chk(cpRdata, 32'h0);
      cp(1'b1, 2'h1, 2'h1, 2'h0, 32'h7);
      chk({cpTrapHyp, cpUndef}, 2'h2);
      cp(1'b1, 2'h1, 2'h3, 2'h0, 32'h7);
      chk({cpTrapHyp, cpUndef}, 2'h1);
      cp(1'b1, 2'h1, 2'h0, 2'h0, 32'h7);
      chk({cpTrapHyp, cpUndef}, 2'h1);
      cp(1'b0, 2'h2, 2'h0, 2'h0, 32'h0);
      chk(cpRdata, 32'h18);
    end
  endtask
  task s_syn;
    begin
      cp(1'b1, 2'h2, 2'h0, 2'h2, 32'h12345678);
      cp(1'b0, 2'h2, 2'h0, 2'h2, 32'h0);
      chk(cpRdata, 32'h12345678);
      for (i = 16; i >= 0; i = i - 1)
        ex(EXC[i*16 +: 16], 1'b0);
      chk(syndrome, 32'h4BFF9012);
      ex(16'h1001, 1'b1);
      ex(16'h0000, 1'b0);
      ex(16'hD000, 1'b0);
      chk(syndrome, 32'h02000000);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // hang guard: the whole sequence needs about a hundred cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  initial begin
    {cpValid, cpWrite, cpToSyndrome, guestTrapGeneral, hypTrapGroupOne, insnValid, insnInItBlock, insnIsBarrier} = 8'h0;
    {accValid, accExclusive, accAcqRel, excValid, excFromLower, excAltCoproc, excVfpAbsent, excCondFail} = 8'h0;
    {curLevel, accSizeLog2, accAddrLow, cpCrm, excKind, insnHw1, excIss, cpWdata} = 88'h0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    s_ctrl;
    s_insn;
    s_align;
    s_access;
    s_syn;
    wrap_up;
  end
endmodule
bind hcs_hyp_control_syndrome hcs_monitor mon (.sys_clk, .rst, .cpValid, .curLevel, .hypTrapGroupOne, .accValid,
  .accAddrLow, .accSizeLog2, .accExclusive, .excValid, .excKind, .excCondFail, .cpDone, .cpRdata, .cpTrapHyp, .alignFault,
  .excTaken, .dataCacheable, .mpuOn, .syndrome);
